// ===== design/rtcw_pkg.sv
/*
  Constants and types for the reset time-out and configuration word block.
  Assumes a 25 MHz device clock that also serves as the oscillator period.
*/
package rtcw_pkg;

  // ---------------------------------------------------------------
  // Clock and time-outs
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_KHZ  = 25000;
  localparam int POWERUP_TIMER_TIME_MS  = 72;
  localparam int BOR_HOLD_MS   = 72;
  localparam int POWERUP_TIMER_CYC_DFLT = POWERUP_TIMER_TIME_MS * CLK_FREQ_KHZ;
  localparam int BOR_CYC_DFLT  = BOR_HOLD_MS * CLK_FREQ_KHZ;
  localparam int OST_TOSC      = 1024;
  localparam int TMR_W         = 21;
  localparam int CLKDIV_W      = 2;

  // ---------------------------------------------------------------
  // Configuration word
  // ---------------------------------------------------------------
  localparam int CFG_W = 14;
  localparam int PM_AW = 11;
  localparam logic [CFG_W-1:0] CFG_ADDR     = 14'h2007;
  localparam logic [CFG_W-1:0] CFG_SPACE_LO = 14'h2000;
  localparam logic [CFG_W-1:0] CFG_SPACE_HI = 14'h3FFF;
  localparam logic [CFG_W-1:0] CFG_ERASED   = 14'h3FFF;
  localparam logic [CFG_W-1:0] RDATA_NONE   = 14'h0000;
  localparam int CFG_OSC_LSB   = 0;
  localparam int CFG_WATCHDOG_ENABLE_BIT  = 2;
  localparam int CFG_POWERUP_TIMER_ENABLE_BIT = 3;
  localparam int CFG_BROWNOUT_ENABLE_BIT = 6;
  localparam int CP_COPIES     = 4;
  localparam int CP_LSB [CP_COPIES] = '{4, 8, 10, 12};

  // Protection bounds
  localparam logic [PM_AW-1:0] PROT_2K_HI = 11'h7FF;
  localparam logic [PM_AW-1:0] PROT_1K_HI = 11'h3FF;
  localparam logic [PM_AW-1:0] PROT_HK_HI = 11'h1FF;
  localparam logic [PM_AW-1:0] PROT_400   = 11'h400;
  localparam logic [PM_AW-1:0] PROT_200   = 11'h200;
  localparam logic [PM_AW-1:0] PROT_100   = 11'h100;
  localparam logic [PM_AW-1:0] PROT_000   = 11'h000;

  // ---------------------------------------------------------------
  // Status and synchroniser layout
  // ---------------------------------------------------------------
  localparam int STAT_BOR_BIT = 0;
  localparam int STAT_POR_BIT = 1;
  localparam int SYN_WDT  = 0;
  localparam int SYN_MASTER_CLEAR_PIN = 1;
  localparam int SYN_BO   = 2;
  localparam int SYN_POR  = 3;
  localparam logic [3:0] SYNC_RST = 4'h2;

  typedef enum logic [1:0] {
    OSC_LP = 2'b00, OSC_XT = 2'b01, OSC_HS = 2'b10, OSC_RC = 2'b11
  } rtcw_osc_t;

  typedef enum logic [1:0] {
    MEM_HALF_K = 2'b00, MEM_1K = 2'b01, MEM_2K = 2'b10
  } rtcw_mem_t;

  typedef enum logic [2:0] {
    ST_POR   = 3'b000,
    ST_POWERUP_TIMER  = 3'b001,
    ST_OST   = 3'b010,
    ST_RUN   = 3'b011,
    ST_SLEEP = 3'b100,
    ST_BOR   = 3'b101
  } rtcw_state_t;

endpackage

// ===== design/rtcw_core_if.sv
/*
  Carrier between the sequencer, its delay timer and the protection decoder.
  Assumes all users sit on the one device clock.
*/
interface rtcw_core_if import rtcw_pkg::*; ();
  logic             start;
  logic [TMR_W-1:0] load;
  logic             done;
  logic             busy;
  logic [CFG_W-1:0] cfg;
  logic             prot_on;
  logic [PM_AW-1:0] prot_lo;
  logic [PM_AW-1:0] prot_hi;
  logic             cp_mismatch;

  modport tmr  (input start, load, output done, busy);
  modport tseq (output start, load, input done, busy);
  modport dec  (input cfg, output prot_on, prot_lo, prot_hi, cp_mismatch);
  modport dseq (output cfg, input prot_on, prot_lo, prot_hi, cp_mismatch);
endinterface

// ===== design/rtcw_delay_timer.sv
/*
  Down-counting delay timer shared by the power-up, brown-out and
  oscillator start-up phases. Assumes the sequencer loads it on start.
*/
module rtcw_delay_timer
  import rtcw_pkg::*;
(
  input wire logic i_clk,       // Device clock
  input wire logic i_srst,      // Synchronous reset, active high
  rtcw_core_if.tmr tmr          // Start, load, done
);

  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    if (tmr.start) begin
      cnt_next = tmr.load;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tmr.busy = (cnt_reg != '0);
  // Count only: the sequencer's start depends on done
  assign tmr.done = (cnt_reg == TMR_W'(1));

  tmr_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
    tmr.start |=> cnt_reg == $past(tmr.load))
    else $error("timer did not load its count");

endmodule // rtcw_delay_timer

// ===== design/rtcw_cfg_decode.sv
/*
  Code-protection decoder for the configuration word copies.
  Assumes the word is steady outside programming mode.
*/
module rtcw_cfg_decode
  import rtcw_pkg::*;
#(
  parameter rtcw_mem_t MEM_SIZE = MEM_2K  // Program memory size
) (
  input wire logic i_clk,       // Device clock
  input wire logic i_srst,      // Synchronous reset, active high
  rtcw_core_if.dec dec          // Word in, protection out
);

  logic [1:0]       copy [CP_COPIES];
  logic [1:0]       pair;
  logic             mis_next, on_next, mis_reg, on_reg;
  logic [PM_AW-1:0] lo_next, hi_next, lo_reg, hi_reg;

  // ---------------------------------------------------------------
  // Pair copies
  // ---------------------------------------------------------------
  for (genvar g = 0; g < CP_COPIES; g++) begin : g_copy
    assign copy[g] = dec.cfg[CP_LSB[g] +: 2];
  end

  always_comb begin
    pair     = 2'h3;
    mis_next = 1'b0;
    for (int i = 0; i < CP_COPIES; i++) begin
      pair     = pair & copy[i];
      mis_next = mis_next | (copy[i] != copy[0]);
    end
    on_next = (pair != 2'b11);
    lo_next = PROT_000;
    hi_next = PROT_2K_HI;
    unique case (MEM_SIZE)
      MEM_2K: begin
        unique case (pair)
          2'b10:   lo_next = PROT_400;
          2'b01:   lo_next = PROT_200;
          default: lo_next = PROT_000;
        endcase
      end
      MEM_1K: begin
        hi_next = PROT_1K_HI;
        on_next = !pair[1];
        lo_next = pair[0] ? PROT_200 : PROT_000;
      end
      default: begin
        hi_next = PROT_HK_HI;
        on_next = !pair[1];
        lo_next = pair[0] ? PROT_100 : PROT_000;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      on_reg  <= 1'b0;
      mis_reg <= 1'b0;
      lo_reg  <= PROT_000;
      hi_reg  <= PROT_2K_HI;
    end else begin
      on_reg  <= on_next;
      mis_reg <= mis_next;
      lo_reg  <= lo_next;
      hi_reg  <= hi_next;
    end
  end

  assign dec.prot_on     = on_reg;
  assign dec.prot_lo     = lo_reg;
  assign dec.prot_hi     = hi_reg;
  assign dec.cp_mismatch = mis_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  prot_2k_a: assert property (MEM_SIZE == MEM_2K && pair == 2'b10
    |=> on_reg && lo_reg == PROT_400 && hi_reg == PROT_2K_HI)
    else $error("2K pair 10 misdecoded");
  prot_1k_a: assert property (MEM_SIZE == MEM_1K && pair == 2'b01
    |=> on_reg && lo_reg == PROT_200 && hi_reg == PROT_1K_HI)
    else $error("1K pair 01 misdecoded");
  prot_half_a: assert property (MEM_SIZE == MEM_HALF_K
    && pair[1] |=> !on_reg)
    else $error("half-K upper codes must leave memory open");
  cp_copy_a: assert property ((dec.cfg[13:12] != dec.cfg[5:4])
    |=> mis_reg && (on_reg || MEM_SIZE != MEM_2K))
    else $error("differing copies not flagged");

endmodule // rtcw_cfg_decode

// ===== design/rtcw_top.sv
/*
  Reset sequencer and configuration word for a small microcontroller:
  power-on, power-up timer, oscillator start-up timer, brown-out hold,
  master clear and sleep wake-up, plus the one-time configuration word.
  Assumes pins and the watchdog wake arrive asynchronously; the
  programming and sleep/status controls come from logic on i_clk.
*/
module rtcw_top
  import rtcw_pkg::*;
#(
  parameter int        POWERUP_TIMER_CYCLES = POWERUP_TIMER_CYC_DFLT, // Power-up timer
  parameter int        BOR_CYCLES  = BOR_CYC_DFLT,  // Brown-out hold
  parameter rtcw_mem_t MEM_SIZE    = MEM_2K         // Program memory
) (
  input  wire logic             i_clk,          // Device clock
  input  wire logic             i_srst,         // Sync reset, high
  input  wire logic             i_por_pulse,    // Power-on pulse, pin
  input  wire logic             i_brownout,     // Brown-out detect, pin
  input  wire logic             i_master_clear_pin_n,       // Master clear, pin
  input  wire logic             i_wdt_wake,     // Watchdog wake level
  input  wire logic             i_irq_wake,     // Enabled interrupt
  input  wire logic             i_sleep_req,    // Core enters sleep
  input  wire logic             i_status_we,    // Status flag write
  input  wire logic [1:0]       i_status_wdata, // Status write data
  input  wire logic             i_prog_mode,    // Programming mode
  input  wire logic             i_prog_we,      // Program write strobe
  input  wire logic [CFG_W-1:0] i_prog_addr,    // Program address
  input  wire logic [CFG_W-1:0] i_prog_wdata,   // Program write data
  output logic      [CFG_W-1:0] o_prog_rdata,   // Program read data
  output logic                  o_core_reset,   // Internal reset
  output logic                  o_sleep,        // Device asleep
  output logic                  o_wdt_enable,   // Watchdog enabled
  output logic      [1:0]       o_osc_mode,     // Oscillator select
  output logic                  o_clkout,       // Second osc pin out
  output logic                  o_clkout_oe_n,  // Clock out enable
  output logic                  o_prot_on,      // Protection active
  output logic      [PM_AW-1:0] o_prot_lo,      // Protected low addr
  output logic      [PM_AW-1:0] o_prot_hi,      // Protected high addr
  output logic                  o_cp_mismatch,  // Copies disagree
  output logic                  o_por_flag,     // Power-on flag
  output logic                  o_bor_flag      // Brown-out flag
);

  rtcw_core_if core ();

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_in, sync1_reg, sync2_reg, sync1_next, sync2_next;

  assign pin_in = {i_por_pulse, i_brownout, i_master_clear_pin_n, i_wdt_wake};

  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_comb begin
      sync1_next[g] = pin_in[g];
      sync2_next[g] = sync1_reg[g];
    end
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        sync1_reg[g] <= SYNC_RST[g];
        sync2_reg[g] <= SYNC_RST[g];
      end else begin
        sync1_reg[g] <= sync1_next[g];
        sync2_reg[g] <= sync2_next[g];
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration word
  // ---------------------------------------------------------------
  logic [CFG_W-1:0] cfg_reg, cfg_next, rdata_reg, rdata_next;
  logic             in_space, cfg_hit;
  rtcw_osc_t        osc_mode;
  logic             xtal, powerup_timer_en, bo_en;

  assign in_space = i_prog_mode && (i_prog_addr >= CFG_SPACE_LO)
                    && (i_prog_addr <= CFG_SPACE_HI);
  assign cfg_hit  = in_space && (i_prog_addr == CFG_ADDR);

  always_comb begin
    cfg_next   = cfg_reg;
    rdata_next = RDATA_NONE;
    if (cfg_hit && i_prog_we) begin
      cfg_next = cfg_reg & i_prog_wdata;
    end
    if (cfg_hit) begin
      rdata_next = cfg_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cfg_reg   <= CFG_ERASED;
      rdata_reg <= RDATA_NONE;
    end else begin
      cfg_reg   <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  assign osc_mode     = rtcw_osc_t'(cfg_reg[CFG_OSC_LSB +: 2]);
  assign xtal         = (osc_mode != OSC_RC);
  assign powerup_timer_en      = !cfg_reg[CFG_POWERUP_TIMER_ENABLE_BIT];
  assign bo_en        = cfg_reg[CFG_BROWNOUT_ENABLE_BIT];
  // Watchdog counter sits outside on its own RC clock
  assign o_wdt_enable = cfg_reg[CFG_WATCHDOG_ENABLE_BIT];
  assign o_osc_mode   = cfg_reg[CFG_OSC_LSB +: 2];
  assign o_prog_rdata = rdata_reg;
  assign core.cfg     = cfg_reg;

  rtcw_cfg_decode #(
    .MEM_SIZE (MEM_SIZE)
  ) u_decode (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .dec    (core)
  );

  assign o_prot_on     = core.prot_on;
  assign o_prot_lo     = core.prot_lo;
  assign o_prot_hi     = core.prot_hi;
  assign o_cp_mismatch = core.cp_mismatch;

  rtcw_delay_timer u_timer (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .tmr    (core)
  );

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  rtcw_state_t state_reg, state_next;
  logic        por_s, bo_hit, master_clear_pin_low, wdt_s, after_tmo;
  logic        core_reset_reg, core_reset_next, sleep_reg, sleep_next;

  assign por_s    = sync2_reg[SYN_POR];
  assign bo_hit   = bo_en && sync2_reg[SYN_BO];
  assign master_clear_pin_low = !sync2_reg[SYN_MASTER_CLEAR_PIN];
  assign wdt_s    = sync2_reg[SYN_WDT];

  // Master clear is not looked at while timing out
  always_comb begin
    state_next = state_reg;
    core.start = 1'b0;
    core.load  = '0;
    after_tmo  = 1'b0;
    if (por_s) begin
      state_next = ST_POR;
    end else if (bo_hit) begin
      // Hold restarts while the supply stays low
      state_next = ST_BOR;
      core.start = 1'b1;
      core.load  = TMR_W'(BOR_CYCLES);
    end else begin
      unique case (state_reg)
        ST_POR: begin
          if (powerup_timer_en) begin
            state_next = ST_POWERUP_TIMER;
            core.start = 1'b1;
            core.load  = TMR_W'(POWERUP_TIMER_CYCLES);
          end else begin
            after_tmo = 1'b1;
          end
        end
        ST_POWERUP_TIMER, ST_BOR, ST_OST: begin
          if (core.done) begin
            if (state_reg == ST_OST) begin
              state_next = ST_RUN;
            end else begin
              after_tmo = 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (i_sleep_req && !master_clear_pin_low) begin
            state_next = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (master_clear_pin_low) begin
            state_next = ST_RUN;
          end else if (wdt_s || i_irq_wake) begin
            after_tmo = 1'b1;
          end
        end
        default: state_next = ST_POR;
      endcase
      if (after_tmo) begin
        if (xtal) begin
          state_next = ST_OST;
          core.start = 1'b1;
          core.load  = TMR_W'(OST_TOSC);
        end else begin
          state_next = ST_RUN;
        end
      end
    end
    core_reset_next = !((state_next == ST_RUN)
                        || (state_next == ST_SLEEP))
                      || master_clear_pin_low;
    sleep_next = (state_next == ST_SLEEP);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg      <= ST_POR;
      core_reset_reg <= 1'b1;
      sleep_reg      <= 1'b0;
    end else begin
      state_reg      <= state_next;
      core_reset_reg <= core_reset_next;
      sleep_reg      <= sleep_next;
    end
  end

  assign o_core_reset = core_reset_reg;
  assign o_sleep      = sleep_reg;

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  logic por_flag_reg, por_flag_next, bor_flag_reg, bor_flag_next;

  // Hardware clear wins over a software write in the same cycle
  always_comb begin
    por_flag_next = por_flag_reg;
    bor_flag_next = bor_flag_reg;
    if (por_s) begin
      por_flag_next = 1'b0;
    end else if (i_status_we) begin
      por_flag_next = i_status_wdata[STAT_POR_BIT];
    end
    if (bo_hit && !por_s) begin
      bor_flag_next = 1'b0;
    end else if (i_status_we) begin
      bor_flag_next = i_status_wdata[STAT_BOR_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      por_flag_reg <= 1'b0;
      bor_flag_reg <= 1'b0;
    end else begin
      por_flag_reg <= por_flag_next;
      bor_flag_reg <= bor_flag_next;
    end
  end

  assign o_por_flag = por_flag_reg;
  assign o_bor_flag = bor_flag_reg;

  // ---------------------------------------------------------------
  // Clock output in RC mode
  // ---------------------------------------------------------------
  logic [CLKDIV_W-1:0] div_reg, div_next;
  logic                clkout_reg, clkout_next, oe_n_reg, oe_n_next;

  always_comb begin
    div_next    = div_reg + 1'b1;
    clkout_next = div_next[CLKDIV_W-1];
    oe_n_next   = (osc_mode != OSC_RC);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_reg    <= '0;
      clkout_reg <= 1'b0;
      oe_n_reg   <= 1'b1;
    end else begin
      div_reg    <= div_next;
      clkout_reg <= clkout_next;
      oe_n_reg   <= oe_n_next;
    end
  end

  assign o_clkout      = clkout_reg;
  assign o_clkout_oe_n = oe_n_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [TMR_W-1:0] dwell_reg, dwell_next;
  logic             leave_norm;

  always_comb begin
    dwell_next = (state_next != state_reg || core.start)
                 ? '0 : dwell_reg + 1'b1;
    leave_norm = (state_next != state_reg) && !por_s && !bo_hit;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dwell_reg <= '0;
    end else begin
      dwell_reg <= dwell_next;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence powerup_timer_then_ost_s;
    state_reg == ST_POWERUP_TIMER ##1 state_reg == ST_OST;
  endsequence

  cfg_polarity_a: assert property (state_reg == ST_POWERUP_TIMER
    |-> !cfg_reg[CFG_POWERUP_TIMER_ENABLE_BIT])
    else $error("power-up timer ran with its bit erased");
  prog_only_a: assert property (!i_prog_mode |=> o_prog_rdata == '0)
    else $error("config word visible outside programming mode");
  powerup_timer_len_a: assert property (state_reg == ST_POWERUP_TIMER && leave_norm
    |-> dwell_reg == TMR_W'(POWERUP_TIMER_CYCLES - 1))
    else $error("power-up timer length wrong");
  ost_order_a: assert property (powerup_timer_then_ost_s |-> xtal)
    else $error("start-up timer used outside crystal mode");
  bor_hold_a: assert property (state_reg == ST_BOR && leave_norm
    |-> dwell_reg >= TMR_W'(BOR_CYCLES - 1))
    else $error("brown-out hold too short");
  wake_src_a: assert property (state_reg == ST_SLEEP
    && state_next != ST_SLEEP
    |-> master_clear_pin_low || wdt_s || i_irq_wake || por_s || bo_hit)
    else $error("sleep left without a wake source");
  powerup_timer_entry_a: assert property ($rose(state_reg == ST_POWERUP_TIMER)
    |-> $past(state_reg) == ST_POR)
    else $error("power-up timer not started from power-on");
  rc_no_tmo_a: assert property (state_reg == ST_POR && !por_s
    && !bo_hit && !xtal && !powerup_timer_en |=> state_reg == ST_RUN)
    else $error("time-out applied in RC mode with timer off");
  master_clear_pin_release_a: assert property (state_reg == ST_RUN
    && !master_clear_pin_low && !por_s && !bo_hit |=> !o_core_reset)
    else $error("execution did not start on master clear release");
  reset_hold_a: assert property (master_clear_pin_low || (state_reg != ST_RUN
    && state_reg != ST_SLEEP && state_next != ST_RUN) |=> o_core_reset)
    else $error("internal reset dropped while a source is active");
  clkout_div_a: assert property ($rose(o_clkout) && !o_clkout_oe_n
    |-> ##1 o_clkout ##1 !o_clkout [*2] ##1 o_clkout)
    else $error("clock output is not divide by four");
  por_flag_a: assert property (por_s |=> !o_por_flag)
    else $error("power-on flag not cleared");
  bor_flag_a: assert property (bo_hit && !por_s |=> !o_bor_flag)
    else $error("brown-out flag not cleared");

endmodule // rtcw_top

// ===== test/rtcw_pin_model.sv
/*
  Pin model of the supply monitor and master-clear switch.
  Assumes the bench sets its requests just after a clock edge.
*/
module rtcw_pin_model (
  input  wire logic i_por,       // Supply ramp request
  input  wire logic i_bo,        // Supply sag request
  input  wire logic i_hold,      // Button held down
  output logic      o_por_pulse, // Power-on pulse
  output logic      o_brownout,  // Brown-out detect
  output logic      o_master_clear_pin_n     // Master clear, pulled up
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_por_pulse = i_por;
  assign o_brownout  = i_bo;
  assign o_master_clear_pin_n    = !i_hold;
endmodule // rtcw_pin_model

// ===== test/rtcw_top_tb_top.sv
/*
  Self-checking bench for rtcw_top with shortened time-outs.
  Assumes the pin model stands in for the supply and master clear.
*/
module rtcw_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcw_pkg::*;
  localparam int NT = 20;
  logic i_clk = 0, i_srst = 1, por = 0, bo = 0, hold = 0, wdt = 0, irq = 0;
  logic slp = 0, swe = 0, pm = 0, pwe = 0, v;
  logic [1:0] swd = 2'h0, osc;
  logic [CFG_W-1:0] pa = 14'h0000, pwd = 14'h0000, rd, w, r1;
  logic cr, sl, wde, ck, oez, pon, cpm, pf, bf, por_p, bo_p, master_clear_pin_n;
  logic [PM_AW-1:0] plo, phi;
  logic [15:0] lf = 16'h002E;
  int errors = 0, checked = 0, cyc = 0, n;
  rtcw_pin_model pins (.i_por(por), .i_bo(bo), .i_hold(hold),
    .o_por_pulse(por_p), .o_brownout(bo_p), .o_master_clear_pin_n(master_clear_pin_n));
  rtcw_top #(.POWERUP_TIMER_CYCLES(NT), .BOR_CYCLES(NT)) dut (.i_clk(i_clk),
    .i_srst(i_srst), .i_por_pulse(por_p), .i_brownout(bo_p),
    .i_master_clear_pin_n(master_clear_pin_n), .i_wdt_wake(wdt), .i_irq_wake(irq),
    .i_sleep_req(slp), .i_status_we(swe), .i_status_wdata(swd),
    .i_prog_mode(pm), .i_prog_we(pwe), .i_prog_addr(pa),
    .i_prog_wdata(pwd), .o_prog_rdata(rd), .o_core_reset(cr),
    .o_sleep(sl), .o_wdt_enable(wde), .o_osc_mode(osc), .o_clkout(ck),
    .o_clkout_oe_n(oez), .o_prot_on(pon), .o_prot_lo(plo),
    .o_prot_hi(phi), .o_cp_mismatch(cpm), .o_por_flag(pf),
    .o_bor_flag(bf));
  always #20 i_clk = !i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // Helpers and reference model
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(int k = 1);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic prog(logic [CFG_W-1:0] a, logic [CFG_W-1:0] d);
    pm = 1;
    pa = a;
    pwe = 1;
    pwd = d;
    tick();
    r1 = rd;
    pwe = 0;
    pa = CFG_ADDR;
    tick();
  endtask
  task automatic drop(int lo, int hi);
    n = 0;
    while (cr !== 1'b0 && n < 1200) begin
      tick();
      n++;
    end
    chk("reset length ok", 16'h0001, 16'(n >= lo && n <= hi));
  endtask
  task automatic pulse();
    por = 1;
    tick(3);
    por = 0;
  endtask
  task automatic seq(int e);
    pulse();
    drop(e, e + 4);
  endtask
  function automatic int tmo(logic [CFG_W-1:0] c);
    return (c[CFG_POWERUP_TIMER_ENABLE_BIT] ? 0 : NT) + (c[1:0] == OSC_RC ? 0 : OST_TOSC);
  endfunction
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    for (int p = 0; p < 4; p++) begin
      i_srst = 1;
      tick(5);
      i_srst = 0;
      lf = lfsr(lf);
      w = {p[1:0], p[1:0], p[1:0], 1'b1, lf[6], p[1:0], lf[3:0]};
      w[3:0] = (p == 3) ? 4'hB : (p == 0) ? 4'h1 : w[3:0];
      prog(14'h2006, 14'h0000);
      chk("other addr", 16'h0000, 16'(r1));
      chk("erased", 16'h3FFF, 16'(rd));
      prog(CFG_ADDR, w);
      chk("word", 16'(w), 16'(rd));
      chk("osc", 16'(w[1:0]), 16'(osc));
      chk("wdt", 16'(w[2]), 16'(wde));
      chk("prot on", 16'(p != 3), 16'(pon));
      if (p != 3) chk("prot lo", (p == 2) ? 16'h0400 : 16'(p * 16'h0200),
                      16'(plo));
      chk("clk oe", 16'(w[1:0] != OSC_RC), 16'(oez));
      pm = 0;
      seq(tmo(w));
      chk("closed", 16'h0000, 16'(rd));
      $display("config pair %0d done", p);
    end
    v = ck;
    tick(2);
    chk("clkout", 16'(!v), 16'(ck));
    hold = 1;
    pulse();
    tick(40);
    chk("held", 16'h0001, 16'(cr));
    hold = 0;
    drop(1, 4);
    swe = 1;
    swd = 2'h3;
    tick();
    swe = 0;
    bo = 1;
    tick(4);
    bo = 0;
    drop(NT, NT + 4);
    chk("bor flag", 16'h0000, 16'(bf));
    chk("por kept", 16'h0001, 16'(pf));
    $display("reset sources done");
    for (int k = 0; k < 3; k++) begin
      slp = 1;
      tick();
      slp = 0;
      tick(2);
      chk("asleep", 16'h0001, 16'(sl));
      {hold, wdt, irq} = 3'h1 << k;
      tick(4);
      chk("woken", 16'h0000, 16'(sl));
      {hold, wdt, irq} = 3'h0;
      tick(4);
    end
    $display("sleep wake done");
    seq(0);
    chk("por flag", 16'h0000, 16'(pf));
    $display("power-on flag done");
    close_out();
  end
endmodule // rtcw_top_tb_top
